// *** verilog/uhd_irq_defines.svh ***
// Register indices, field positions, reset values and timing for the USB interrupt logic
`ifndef UHD_IRQ_DEFINES_SVH
`define UHD_IRQ_DEFINES_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define UHD_IDX_HOP_STAT 8'h03
`define UHD_IDX_HOP_EN 8'h04
`define UHD_IDX_HHW 8'h20
`define UHD_IDX_HUP_STAT 8'h24
`define UHD_IDX_HUP_EN 8'h25
`define UHD_IDX_DMODE 8'hB9
`define UHD_IDX_DHW 8'hBB
`define UHD_IDX_DSTAT 8'hC0
`define UHD_IDX_DEN 8'hC1
`define UHD_IDX_EP_BASE 8'hD0
// ==========================================================
// Field positions
`define UHD_HHW_LATCH_EN 0
`define UHD_HHW_TRIG 1
`define UHD_HHW_POL 2
`define UHD_HOP_MIE 31
`define UHD_HUP_OPR 0
`define UHD_DHW_POL 0
`define UHD_DHW_PULSE 1
`define UHD_DMODE_GEN 3
`define UHD_DST_LIVE 0
`define UHD_DST_SOF 5
`define UHD_DST_PSEUDO_FRAME_START_EVENT 6
`define UHD_DST_SUSP 7
`define UHD_DST_EP_LO 8
// ==========================================================
// Reset values
`define UHD_RST_HHW 3'h0
`define UHD_RST_DHW 2'h0
`define UHD_RST_DMODE 8'h00
// ==========================================================
// Timing
`define UHD_CLK_MHZ 250
`define UHD_PULSE_NS 166
`define UHD_PULSE_CYCLES ((`UHD_PULSE_NS * `UHD_CLK_MHZ + 999) / 1000)
`define UHD_FRAME_US 1000
`define UHD_FRAME_CYCLES (`UHD_FRAME_US * `UHD_CLK_MHZ)
`define UHD_MISSED_SOF_LIMIT 2'd3
`endif

// *** verilog/uhd_pkg.sv ***
// Types shared by the USB interrupt logic
package uhd_pkg;
   typedef enum logic [0:0] {
      UHD_BUS_IDLE = 1'b0,
      UHD_BUS_ACK = 1'b1
   } uhd_bus_state_t;
   typedef logic [7:0] uhd_index_t;
endpackage : uhd_pkg

// *** verilog/uhd_irq_logic.sv ***
// Host and device interrupt request logic with Avalon-MM register slave
`timescale 1ns/1ps
`include "uhd_irq_defines.svh"
// How it works
// - Two request outputs: one fed by host events, one by device events only.
// - Each output: level low, level high, edge low, edge high; level low after reset.
// - Host trigger and polarity bits pick mode; pin-enable bit gates the host latch.
// - Host processor events reach the output only when enabled and pin-enable set.
// - Operational events only set the summary flag, never the output directly.
// - Enabled operational bits OR-ed, AND-ed with master enable, set summary flag.
// - Enabled processor bits OR-ed into a latch gated by pin-enable.
// - With pin-enable clear the host latch holds its present state.
// - Device polarity and level/pulse bits pick mode; global enable in mode register.
// - Each device event sets own status bit; enable bit decides interrupt.
// - Device level low after reset; pulse mode gives 42-cycle (168 ns) pulse on rise.
// - Bus bits clear on status read; endpoint bits clear on endpoint read.
// - Live bus state bit follows the bus directly, never latched.
// - Endpoint events arrive only after acknowledged packets, every bulk ACK.
// - Missing start-of-frame raises pseudo frame event every 1 ms, own enable.
// - Three missed start-of-frame events enter suspend.
// - Events with global enable low still log; raising enable asserts if pending.
// - Clearing global enable never withdraws an asserted device output.
module uhd_irq_logic #(
   parameter int FRAME_CYCLES = `UHD_FRAME_CYCLES,
   parameter int PULSE_CYCLES = `UHD_PULSE_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [5:0] host_op_event,
   input wire logic [4:0] host_proc_event,
   input wire logic live_bus_state,
   input wire logic [4:0] dev_bus_event,
   input wire logic [15:0] dev_ep_event,
   output logic host_irq_out,
   output logic device_irq_out,
   output logic suspend_out
);
   import uhd_pkg::*;

   localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
   localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);
   localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);

   function automatic logic [31:0] uhd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : uhd_merge

   function automatic logic uhd_pin(input logic edge_mode, input logic pol, input logic level,
                                    input logic pulse);
      logic act;
      act = edge_mode ? pulse : level;
      return pol ? act : ~act;
   endfunction : uhd_pin

   // ==========================================================
   // Bus slave
   uhd_bus_state_t bus_state_q, bus_state_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   uhd_index_t idx;
   logic req, wr_go, rd_go;
   logic [31:0] wmask;

   // Host registers
   logic [5:0] hop_stat_q, hop_stat_d;
   logic [5:0] hop_en_q, hop_en_d;
   logic mie_q, mie_d;
   logic [2:0] hhw_q, hhw_d;
   logic [5:0] hup_stat_q, hup_stat_d;
   logic [5:0] hup_en_q, hup_en_d;
   logic hlatch_q, hlatch_d;
   logic [PULSE_W-1:0] hpulse_q, hpulse_d;
   logic hout_q, hout_d;

   // Device registers
   logic [7:0] dmode_q, dmode_d;
   logic [1:0] dhw_q, dhw_d;
   logic [23:1] dstat_q, dstat_d;
   logic [23:0] den_q, den_d;
   logic dassert_q, dassert_d;
   logic [PULSE_W-1:0] dpulse_q, dpulse_d;
   logic dout_q, dout_d;
   logic [FRAME_W-1:0] frame_q, frame_d;
   logic [1:0] missed_q, missed_d;
   logic susp_q, susp_d;
   logic dany;
   logic [23:0] dview;

   assign idx = avs_address[9:2];
   assign req = avs_read | avs_write;
   // Effects happen once, on the edge where waitrequest is sampled low
   assign wr_go = avs_write && (bus_state_q == UHD_BUS_ACK);
   assign rd_go = avs_read && (bus_state_q == UHD_BUS_ACK);
   assign wmask = uhd_merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable);
   assign dview = {dstat_q, live_bus_state};
   assign dany = |(dview & den_q);

   always_comb begin
      bus_state_d = bus_state_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      case (bus_state_q)
         UHD_BUS_IDLE: begin
            if (req) begin
               bus_state_d = UHD_BUS_ACK;
               wait_d = 1'b0;
               rdata_d = 32'h0000_0000;
               if (avs_read) begin
                  case (idx)
                     `UHD_IDX_HOP_STAT: rdata_d = {26'h0, hop_stat_q};
                     `UHD_IDX_HOP_EN: rdata_d = {mie_q, 25'h0, hop_en_q};
                     `UHD_IDX_HHW: rdata_d = {29'h0, hhw_q};
                     `UHD_IDX_HUP_STAT: rdata_d = {26'h0, hup_stat_q};
                     `UHD_IDX_HUP_EN: rdata_d = {26'h0, hup_en_q};
                     `UHD_IDX_DMODE: rdata_d = {24'h0, dmode_q};
                     `UHD_IDX_DHW: rdata_d = {30'h0, dhw_q};
                     `UHD_IDX_DSTAT: rdata_d = {8'h0, dview};
                     `UHD_IDX_DEN: rdata_d = {8'h0, den_q};
                     default: begin
                        if (idx[7:4] == 4'(`UHD_IDX_EP_BASE >> 4)) begin
                           rdata_d = {31'h0, dstat_q[`UHD_DST_EP_LO + idx[3:0]]};
                        end
                     end
                  endcase
               end
            end
         end
         UHD_BUS_ACK: begin
            bus_state_d = UHD_BUS_IDLE;
            wait_d = 1'b1;
         end
         default: begin
            bus_state_d = UHD_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus_state_q <= UHD_BUS_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         bus_state_q <= bus_state_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   // ==========================================================
   // Host interrupt tree
   always_comb begin
      logic [31:0] w;
      w = avs_writedata & wmask;
      hop_en_d = hop_en_q;
      mie_d = mie_q;
      hhw_d = hhw_q;
      hup_en_d = hup_en_q;
      hop_stat_d = hop_stat_q;
      hup_stat_d = hup_stat_q;
      if (wr_go && idx == `UHD_IDX_HOP_EN) begin
         hop_en_d = (hop_en_q & ~wmask[5:0]) | w[5:0];
         mie_d = wmask[`UHD_HOP_MIE] ? w[`UHD_HOP_MIE] : mie_q;
      end
      if (wr_go && idx == `UHD_IDX_HHW) begin
         hhw_d = (hhw_q & ~wmask[2:0]) | w[2:0];
      end
      if (wr_go && idx == `UHD_IDX_HUP_EN) begin
         hup_en_d = (hup_en_q & ~wmask[5:0]) | w[5:0];
      end
      // Write-one-to-clear; a new event wins over the clear
      if (wr_go && idx == `UHD_IDX_HOP_STAT) begin
         hop_stat_d = hop_stat_q & ~w[5:0];
      end
      hop_stat_d = hop_stat_d | host_op_event;
      // Plain write so software can both clear and set
      if (wr_go && idx == `UHD_IDX_HUP_STAT) begin
         hup_stat_d = (hup_stat_q & ~wmask[5:0]) | w[5:0];
      end
      hup_stat_d[5:1] = hup_stat_d[5:1] | host_proc_event;
      if (mie_q && |(hop_stat_q & hop_en_q)) begin
         hup_stat_d[`UHD_HUP_OPR] = 1'b1;
      end
      // Latch follows enabled OR only while pin-enable set
      hlatch_d = hlatch_q;
      if (hhw_q[`UHD_HHW_LATCH_EN]) begin
         hlatch_d = |(hup_stat_q & hup_en_q);
      end
      hpulse_d = hpulse_q;
      if (hlatch_d && !hlatch_q) begin
         hpulse_d = PULSE_LOAD;
      end else if (hpulse_q != '0) begin
         hpulse_d = hpulse_q - 1'b1;
      end
      hout_d = uhd_pin(hhw_d[`UHD_HHW_TRIG], hhw_d[`UHD_HHW_POL], hlatch_d, hpulse_d != '0);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hop_stat_q <= 6'h00;
         hop_en_q <= 6'h00;
         mie_q <= 1'b0;
         hhw_q <= `UHD_RST_HHW;
         hup_stat_q <= 6'h00;
         hup_en_q <= 6'h00;
         hlatch_q <= 1'b0;
         hpulse_q <= '0;
         hout_q <= 1'b1;
      end else begin
         hop_stat_q <= hop_stat_d;
         hop_en_q <= hop_en_d;
         mie_q <= mie_d;
         hhw_q <= hhw_d;
         hup_stat_q <= hup_stat_d;
         hup_en_q <= hup_en_d;
         hlatch_q <= hlatch_d;
         hpulse_q <= hpulse_d;
         hout_q <= hout_d;
      end
   end

   assign host_irq_out = hout_q;

   // ==========================================================
   // Device interrupt and frame supervision
   always_comb begin
      logic [31:0] w;
      logic frame_end;
      w = avs_writedata & wmask;
      frame_end = 1'b0;
      dmode_d = dmode_q;
      dhw_d = dhw_q;
      den_d = den_q;
      dstat_d = dstat_q;
      if (wr_go && idx == `UHD_IDX_DMODE) begin
         dmode_d = (dmode_q & ~wmask[7:0]) | w[7:0];
      end
      if (wr_go && idx == `UHD_IDX_DHW) begin
         dhw_d = (dhw_q & ~wmask[1:0]) | w[1:0];
      end
      if (wr_go && idx == `UHD_IDX_DEN) begin
         den_d = (den_q & ~wmask[23:0]) | w[23:0];
      end
      if (rd_go && idx == `UHD_IDX_DSTAT) begin
         dstat_d[7:1] = 7'h00;
      end
      if (rd_go && idx[7:4] == 4'(`UHD_IDX_EP_BASE >> 4)) begin
         dstat_d[`UHD_DST_EP_LO + idx[3:0]] = 1'b0;
      end
      // Frame timer restarts on every real start-of-frame
      frame_d = frame_q + 1'b1;
      missed_d = missed_q;
      susp_d = susp_q;
      if (dev_bus_event[`UHD_DST_SOF - 1]) begin
         frame_d = '0;
         missed_d = 2'd0;
         susp_d = 1'b0;
      end else if (frame_q == FRAME_LAST) begin
         frame_d = '0;
         frame_end = 1'b1;
         if (missed_q != `UHD_MISSED_SOF_LIMIT) begin
            missed_d = missed_q + 1'b1;
         end
         if (missed_q == `UHD_MISSED_SOF_LIMIT - 2'd1) begin
            susp_d = 1'b1;
         end
      end
      // Events set after clears so a same-cycle event is kept
      dstat_d[5:1] = dstat_d[5:1] | dev_bus_event;
      dstat_d[23:8] = dstat_d[23:8] | dev_ep_event;
      dstat_d[`UHD_DST_PSEUDO_FRAME_START_EVENT] = dstat_d[`UHD_DST_PSEUDO_FRAME_START_EVENT] | frame_end;
      dstat_d[`UHD_DST_SUSP] = dstat_d[`UHD_DST_SUSP] | (susp_d & ~susp_q);
      // Enable low holds the request: blocks both new assertion and withdrawal
      dassert_d = dmode_q[`UHD_DMODE_GEN] ? dany : dassert_q;
      dpulse_d = dpulse_q;
      if (dassert_d && !dassert_q) begin
         dpulse_d = PULSE_LOAD;
      end else if (dpulse_q != '0) begin
         dpulse_d = dpulse_q - 1'b1;
      end
      dout_d = uhd_pin(dhw_d[`UHD_DHW_PULSE], dhw_d[`UHD_DHW_POL], dassert_d, dpulse_d != '0);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dmode_q <= `UHD_RST_DMODE;
         dhw_q <= `UHD_RST_DHW;
         den_q <= 24'h00_0000;
         dstat_q <= 23'h00_0000;
         dassert_q <= 1'b0;
         dpulse_q <= '0;
         dout_q <= 1'b1;
         frame_q <= '0;
         missed_q <= 2'd0;
         susp_q <= 1'b0;
      end else begin
         dmode_q <= dmode_d;
         dhw_q <= dhw_d;
         den_q <= den_d;
         dstat_q <= dstat_d;
         dassert_q <= dassert_d;
         dpulse_q <= dpulse_d;
         dout_q <= dout_d;
         frame_q <= frame_d;
         missed_q <= missed_d;
         susp_q <= susp_d;
      end
   end

   assign device_irq_out = dout_q;
   assign suspend_out = susp_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic hor_any;
   logic frame_last;
   assign hor_any = |(hup_stat_q & hup_en_q);
   assign frame_last = frame_q == FRAME_LAST;

   sequence s_hrise_edge;
      $rose(hlatch_q) && hhw_q[`UHD_HHW_TRIG] && hhw_q[`UHD_HHW_POL] && $stable(hhw_q);
   endsequence
   sequence s_dstat_read;
      rd_go && idx == `UHD_IDX_DSTAT && dev_bus_event == 5'h00 && !(susp_d & ~susp_q);
   endsequence

   AST_HOST_HOLD: assert property (!hhw_q[`UHD_HHW_LATCH_EN] |=> $stable(hlatch_q))
      else $error("host latch moved while pin-enable clear");
   AST_HOST_LATCH: assert property (hhw_q[`UHD_HHW_LATCH_EN] |=> hlatch_q == $past(hor_any))
      else $error("host latch does not follow enabled OR");
   AST_HOST_LEVEL: assert property (!hhw_q[`UHD_HHW_TRIG] |-> hout_q == (hhw_q[`UHD_HHW_POL] ~^ hlatch_q))
      else $error("host level output wrong");
   AST_HOST_PULSE: assert property (s_hrise_edge |-> hout_q [*8])
      else $error("host edge pulse too short");
   AST_OPR_SET: assert property ((mie_q && |(hop_stat_q & hop_en_q)) |=> hup_stat_q[`UHD_HUP_OPR])
      else $error("summary flag not set");
   AST_OPR_MASK: assert property ((!mie_q && !hup_stat_q[`UHD_HUP_OPR] && !(wr_go && idx == `UHD_IDX_HUP_STAT))
                                  |=> !hup_stat_q[`UHD_HUP_OPR])
      else $error("summary flag set with master enable clear");
   AST_DEV_ASSERT: assert property ((dmode_q[`UHD_DMODE_GEN] && dany) |=> dassert_q)
      else $error("device request not asserted");
   AST_DEV_KEEP: assert property ((!dmode_q[`UHD_DMODE_GEN] && dassert_q) |=> dassert_q)
      else $error("device request withdrawn by enable");
   AST_DEV_RDCLR: assert property (s_dstat_read |=> dstat_q[7:1] == 7'h00 || $past(frame_last))
      else $error("bus status bits not cleared by read");
   AST_SUSPEND: assert property ($rose(susp_q) |-> $past(missed_q) == 2'd2 && missed_q == 2'd3)
      else $error("suspend entered at wrong missed count");
   AST_BUS_ANSWER: assert property ((req && bus_state_q == UHD_BUS_IDLE) |=> !wait_q ##1 wait_q)
      else $error("waitrequest not released for one cycle");

endmodule : uhd_irq_logic

// *** sim/uhd_cpu_model.sv ***
// Microprocessor model: Avalon-MM master and interrupt service procedures
`timescale 1ns/1ps
`include "uhd_irq_defines.svh"
module uhd_cpu_model (
   input wire logic mclk,
   output logic [9:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   output logic bus_hang
);
   initial begin
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      bus_hang = 1'b0;
   end
   // ==========================================================
   // Bus cycle, held until waitrequest is seen low
   task automatic xfer(input logic rnw, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
      int n;
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      avs_read <= rnw;
      avs_write <= ~rnw;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdat = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         bus_hang <= 1'b1;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released data lines must not keep showing the last value
      avs_writedata <= ~wd;
   endtask : xfer
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b0, idx, d, x);
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      xfer(1'b1, idx, 32'h0000_0000, d);
   endtask : rd
   // ==========================================================
   // Service procedures
   task automatic host_mask(input logic [2:0] mode);
      logic [31:0] cfg;
      rd(`UHD_IDX_HHW, cfg);
      if (cfg[`UHD_HHW_LATCH_EN] !== 1'b1) begin
         wr(`UHD_IDX_HHW, {29'h0, mode | 3'b001});
      end
      wr(`UHD_IDX_HUP_EN, 32'h0000_0000);
      wr(`UHD_IDX_HHW, {29'h0, mode & 3'b110});
   endtask : host_mask
   task automatic host_disable(input logic [2:0] mode);
      wr(`UHD_IDX_HHW, {29'h0, mode | 3'b001});
      wr(`UHD_IDX_HUP_STAT, 32'h0000_0000);
      wr(`UHD_IDX_HHW, {29'h0, mode & 3'b110});
   endtask : host_disable
   // Global enable raised first so clearing reads can drop the pin
   task automatic dev_service(input int ep, output logic [31:0] st, output logic [31:0] es);
      wr(`UHD_IDX_DMODE, 32'h0000_0008);
      rd(`UHD_IDX_DSTAT, st);
      rd(`UHD_IDX_EP_BASE + 8'(ep), es);
   endtask : dev_service
endmodule : uhd_cpu_model

// *** sim/tb_top.sv ***
// Self-checking bench for the USB interrupt logic
`timescale 1ns/1ps
`include "uhd_irq_defines.svh"
module tb_top;
   import uhd_pkg::*;
   localparam int FRAME = 200;
   localparam int PULSE = 10;
   localparam logic [7:0] ZIDX [5] = '{`UHD_IDX_HHW, `UHD_IDX_DHW, `UHD_IDX_DMODE, `UHD_IDX_HUP_EN, 8'h7F};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, bus_hang;
   logic [31:0] avs_writedata, avs_readdata, rv, es;
   logic [3:0] avs_byteenable;
   logic [5:0] host_op_event = 6'h00;
   logic [4:0] host_proc_event = 5'h00;
   logic live_bus_state = 1'b0;
   logic [4:0] dev_bus_event = 5'h00;
   logic [15:0] dev_ep_event = 16'h0000;
   logic host_irq_out, device_irq_out, suspend_out;
   int failures = 0;
   int checked = 0;
   int seed = 10;
   int cnt, k, j, e;
   always #2 mclk = ~mclk;
   uhd_irq_logic #(.FRAME_CYCLES(FRAME), .PULSE_CYCLES(PULSE)) i_uhd_irq_logic (.mclk(mclk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .host_op_event(host_op_event), .host_proc_event(host_proc_event), .live_bus_state(live_bus_state),
      .dev_bus_event(dev_bus_event), .dev_ep_event(dev_ep_event), .host_irq_out(host_irq_out),
      .device_irq_out(device_irq_out), .suspend_out(suspend_out));
   uhd_cpu_model i_uhd_cpu_model (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_hang(bus_hang));
   // ==========================================================
   // Checking and reporting
   task automatic finish_test();
      $display("counts: %0d failures, %0d checked", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: pin level %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit
   function automatic logic pin(input int sel);
      return (sel == 0) ? host_irq_out : ((sel == 1) ? device_irq_out : suspend_out);
   endfunction : pin
   task automatic wait_pin(input int sel, input logic lvl, input int lim, output int n);
      n = 0;
      while (pin(sel) !== lvl && n < lim) begin
         @(posedge mclk);
         n++;
      end
      checked++;
      if (pin(sel) !== lvl) begin
         failures++;
         $display("wrong value at %0t: pin %0d never reached %b", $time, sel, lvl);
         finish_test();
      end
   endtask : wait_pin
   task automatic pulse_len(input int sel, input logic lvl, output int n);
      n = 0;
      while (pin(sel) === lvl && n < 100) begin
         @(posedge mclk);
         n++;
      end
   endtask : pulse_len
   // One-cycle event pulse: 0 op, 1 processor, 2 device bus, 3 endpoint
   task automatic ev(input int kind, input int b);
      @(posedge mclk);
      case (kind)
         0: host_op_event[b] <= 1'b1;
         1: host_proc_event[b] <= 1'b1;
         2: dev_bus_event[b] <= 1'b1;
         default: dev_ep_event[b] <= 1'b1;
      endcase
      @(posedge mclk);
      host_op_event <= 6'h00;
      host_proc_event <= 5'h00;
      dev_bus_event <= 5'h00;
      dev_ep_event <= 16'h0000;
   endtask : ev
   always @(posedge mclk) begin
      if (bus_hang === 1'b1) begin
         failures++;
         $display("wrong value at %0t: bus access never answered", $time);
         finish_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk_bit(host_irq_out, 1'b1);
      chk_bit(device_irq_out, 1'b1);
      chk_bit(suspend_out, 1'b0);
      for (int i = 0; i < 5; i++) begin
         i_uhd_cpu_model.rd(ZIDX[i], rv);
         chk_val(rv, 32'h0000_0000);
      end
      rv = $random(seed);
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, {24'h0, rv[7:0] & 8'hF7});
      i_uhd_cpu_model.rd(`UHD_IDX_DMODE, es);
      chk_val(es, {24'h0, rv[7:0] & 8'hF7});
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, 32'h0000_0000);
      // Host level mode 0, one enabled processor event
      k = $unsigned($random(seed)) % 5;
      j = $unsigned($random(seed)) % 6;
      e = $unsigned($random(seed)) % 16;
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_EN, 32'h1 << (k + 1));
      i_uhd_cpu_model.wr(`UHD_IDX_HHW, 32'h0000_0001);
      ev(1, (k + 1) % 5);
      repeat (4) @(posedge mclk);
      chk_bit(host_irq_out, 1'b1);
      ev(1, k);
      wait_pin(0, 1'b0, 10, cnt);
      i_uhd_cpu_model.rd(`UHD_IDX_HUP_STAT, rv);
      chk_val(rv, (32'h1 << (k + 1)) | (32'h1 << ((k + 1) % 5 + 1)));
      i_uhd_cpu_model.wr(`UHD_IDX_HHW, 32'h0000_0005);
      wait_pin(0, 1'b1, 10, cnt);
      i_uhd_cpu_model.host_mask(3'b100);
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_STAT, 32'h0000_0000);
      ev(1, k);
      repeat (4) @(posedge mclk);
      chk_bit(host_irq_out, 1'b0);
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_EN, 32'h1 << (k + 1));
      repeat (4) @(posedge mclk);
      chk_bit(host_irq_out, 1'b0);
      i_uhd_cpu_model.wr(`UHD_IDX_HHW, 32'h0000_0005);
      wait_pin(0, 1'b1, 10, cnt);
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_STAT, 32'h0000_0000);
      wait_pin(0, 1'b0, 10, cnt);
      // Operational group reaches the pin only through the summary flag
      i_uhd_cpu_model.wr(`UHD_IDX_HOP_EN, 32'h1 << j);
      ev(0, j);
      i_uhd_cpu_model.rd(`UHD_IDX_HUP_STAT, rv);
      chk_val(rv, 32'h0000_0000);
      i_uhd_cpu_model.wr(`UHD_IDX_HOP_EN, 32'h8000_0000 | (32'h1 << j));
      i_uhd_cpu_model.rd(`UHD_IDX_HUP_STAT, rv);
      chk_val(rv, 32'h0000_0001);
      i_uhd_cpu_model.rd(`UHD_IDX_HOP_STAT, rv);
      chk_val(rv, 32'h1 << j);
      chk_bit(host_irq_out, 1'b0);
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_EN, 32'h0000_0001);
      wait_pin(0, 1'b1, 10, cnt);
      i_uhd_cpu_model.wr(`UHD_IDX_HOP_STAT, 32'h1 << j);
      i_uhd_cpu_model.host_disable(3'b100);
      chk_bit(host_irq_out, 1'b0);
      // Host edge mode, active high
      i_uhd_cpu_model.wr(`UHD_IDX_HUP_EN, 32'h0000_0002);
      i_uhd_cpu_model.wr(`UHD_IDX_HHW, 32'h0000_0007);
      ev(1, 0);
      wait_pin(0, 1'b1, 10, cnt);
      pulse_len(0, 1'b1, cnt);
      chk_val(cnt, PULSE);
      // Device side
      i_uhd_cpu_model.wr(`UHD_IDX_DEN, 32'h0000_0002 | (32'h1 << (8 + e)));
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, 32'h0000_0008);
      live_bus_state <= 1'b1;
      i_uhd_cpu_model.rd(`UHD_IDX_DSTAT, rv);
      chk_val(rv & 32'h0000_003F, 32'h0000_0001);
      live_bus_state <= 1'b0;
      ev(2, 0);
      wait_pin(1, 1'b0, 10, cnt);
      i_uhd_cpu_model.rd(`UHD_IDX_DSTAT, rv);
      chk_val(rv & 32'h00FF_FF3F, 32'h0000_0002);
      wait_pin(1, 1'b1, 10, cnt);
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, 32'h0000_0000);
      ev(3, e);
      repeat (4) @(posedge mclk);
      chk_bit(device_irq_out, 1'b1);
      i_uhd_cpu_model.rd(`UHD_IDX_DSTAT, rv);
      chk_val(rv & 32'h00FF_FF3F, 32'h1 << (8 + e));
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, 32'h0000_0008);
      wait_pin(1, 1'b0, 10, cnt);
      i_uhd_cpu_model.wr(`UHD_IDX_DMODE, 32'h0000_0000);
      repeat (4) @(posedge mclk);
      chk_bit(device_irq_out, 1'b0);
      i_uhd_cpu_model.dev_service(e, rv, es);
      chk_val(es, 32'h0000_0001);
      wait_pin(1, 1'b1, 10, cnt);
      // Pulse mode, active low
      i_uhd_cpu_model.wr(`UHD_IDX_DHW, 32'h0000_0002);
      ev(2, 0);
      wait_pin(1, 1'b0, 10, cnt);
      pulse_len(1, 1'b0, cnt);
      chk_val(cnt, PULSE);
      // Level active high: clearing the pending bit drops the pin
      i_uhd_cpu_model.wr(`UHD_IDX_DHW, 32'h0000_0001);
      i_uhd_cpu_model.rd(`UHD_IDX_DSTAT, rv);
      wait_pin(1, 1'b0, 10, cnt);
      i_uhd_cpu_model.wr(`UHD_IDX_DHW, 32'h0000_0000);
      // Missing frame starts: pseudo event each frame, suspend after three
      ev(2, 4);
      i_uhd_cpu_model.rd(`UHD_IDX_DSTAT, rv);
      i_uhd_cpu_model.wr(`UHD_IDX_DEN, 32'h0000_0040);
      wait_pin(1, 1'b0, FRAME + 10, cnt);
      chk_bit(cnt > FRAME - 20, 1'b1);
      chk_bit(suspend_out, 1'b0);
      wait_pin(2, 1'b1, 2 * FRAME + 20, cnt);
      chk_bit(cnt > FRAME, 1'b1);
      ev(2, 4);
      wait_pin(2, 1'b0, 10, cnt);
      finish_test();
   end
endmodule : tb_top
